// ---- hdl/gpio_p23_cfg.svh ----
`ifndef GPIO_P23_CFG_SVH
`define GPIO_P23_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_CONV_MODE 16'hffc4
`define IDX_P2_FSEL 16'hffc9
`define IDX_P3_FSEL 16'hffca
`define IDX_P2_DATA 16'hffd5
`define IDX_P3_DATA 16'hffd6
`define IDX_P3_PULL 16'hffe1
`define IDX_P2_DIR 16'hffe5
`define IDX_P3_DIR 16'hffe6

// ----------------------------------------------------------------
// Reset values and fixed read values
// ----------------------------------------------------------------
`define RST_ZERO 8'h00
`define RST_P2_FSEL 8'hc0
`define P2_FSEL_FIXED 8'hc0
`define P2_FSEL_WMASK 8'h3f
`define WO_READ 8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_INT4_SEL 0
`define BIT_COUNT_SEL 1
`define BIT_TRIG_EN 0
`define PIN_INT4 0
`define PIN_COUNT 1

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/gpio_p23_pkg.sv ----
package gpio_p23_pkg;

   typedef enum logic [2:0] {
      PM_RESET = 3'b000,
      PM_ACTIVE = 3'b001,
      PM_SUBACTIVE = 3'b010,
      PM_SLEEP = 3'b011,
      PM_SUBSLEEP = 3'b100,
      PM_WATCH = 3'b101,
      PM_STANDBY = 3'b110
   } pmode_t;

   typedef enum logic [3:0] {
      REG_NONE = 4'b0000,
      REG_CONV_MODE = 4'b0001,
      REG_P2_FSEL = 4'b0010,
      REG_P3_FSEL = 4'b0011,
      REG_P2_DATA = 4'b0100,
      REG_P3_DATA = 4'b0101,
      REG_P3_PULL = 4'b0110,
      REG_P2_DIR = 4'b0111,
      REG_P3_DIR = 4'b1000
   } reg_id_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } pin_drive_t;

   typedef struct packed {
      logic count_dir;
      logic interrupt4;
      logic trigger;
   } p2_alt_t;

endpackage

// ---- hdl/pin_sync2.sv ----
`timescale 1ns/100ps

module pin_sync2 #(
   parameter int W = 8
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         q <= '0;
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // pin_sync2

// ---- hdl/gpio_p23.sv ----
// Notes on behaviour
// - Pin 1 follows direction unless count select is 1, then count input.
// - Pin 0 is interrupt-4 input when selected; trigger input too if enabled.
// - Port 2 floats in reset/standby, holds in sleep/subsleep/watch, runs in active and subactive.
// - Port 3 has eight bidirectional pins, each with data and direction bits.
// - Port 3 data register holds one bit per pin, cleared on reset.
// - Port 3 read returns stored data where direction bit is 1.
// - Port 3 read returns the sampled pin level where direction bit is 0.
// - Port 3 direction bit 1 drives the pin, 0 makes it an input.
// - Port 3 data and direction set the drive only on pins selected as plain I/O.
// - Port 3 direction register is write-only and reads as all ones.
// - Port 3 direction resets to zero, so all pins start as inputs.
// - Port 2 read returns data where direction is 1, pin level otherwise.
// - Port 3 function select: 0 keeps plain I/O, 1 hands pin to peripheral.
`timescale 1ns/100ps
`include "gpio_p23_cfg.svh"

module gpio_p23
   import gpio_p23_pkg::*;
#(
   parameter int ADDR_W = 18
) (
   input wire logic aclk, // System clock, 200 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire pmode_t pmode, // Operating mode of the chip
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [ADDR_W-1:0] awaddr, // Write byte address
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   output logic [1:0] bresp, // Write response
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   input wire logic [ADDR_W-1:0] araddr, // Read byte address
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   input wire logic [7:0] p2_pin_in, // Port 2 pin levels
   output pin_drive_t p2_drv, // Port 2 pin drivers
   output p2_alt_t p2_alt, // Port 2 inputs to peripherals
   input wire logic [7:0] p3_pin_in, // Port 3 pin levels
   output pin_drive_t p3_drv, // Port 3 pin drivers
   output logic [7:0] p3_pullup_on, // Port 3 pull-up enables
   input wire logic [7:0] p3_alt_out, // Peripheral data for port 3
   input wire logic [7:0] p3_alt_en // Peripheral drive enables, high drives
);

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic reg_id_t reg_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-3:0] idx;
      idx = a[ADDR_W-1:2];
      case (idx)
         `IDX_CONV_MODE: reg_of = REG_CONV_MODE;
         `IDX_P2_FSEL: reg_of = REG_P2_FSEL;
         `IDX_P3_FSEL: reg_of = REG_P3_FSEL;
         `IDX_P2_DATA: reg_of = REG_P2_DATA;
         `IDX_P3_DATA: reg_of = REG_P3_DATA;
         `IDX_P3_PULL: reg_of = REG_P3_PULL;
         `IDX_P2_DIR: reg_of = REG_P2_DIR;
         `IDX_P3_DIR: reg_of = REG_P3_DIR;
         default: reg_of = REG_NONE;
      endcase
   endfunction

   // Output-direction bits show stored data, input bits show the pin
   function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] data,
                                            input logic [7:0] pin);
      port_view = (dir & data) | (~dir & pin);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] data2_q, dir2_q, fsel2_q;
   logic [7:0] data3_q, dir3_q, fsel3_q, pull3_q;
   logic trig_en_q;
   logic aw_have_q, w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wstrb0_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   pin_drive_t p2_drv_q, p3_drv_q;
   p2_alt_t p2_alt_q;
   logic [7:0] p3_pull_q;
   logic [7:0] pin2_s, pin3_s;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pin_sync2 #(
      .W(16)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d({p3_pin_in, p2_pin_in}),
      .q({pin3_s, pin2_s})
   );

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Handshakes only count while ce is high, so the bus must run with ce set.
   wire aw_hs = ce & awvalid & awready_q;
   wire w_hs = ce & wvalid & wready_q;
   wire aw_all = aw_have_q | aw_hs;
   wire w_all = w_have_q | w_hs;
   wire do_write = aw_all & w_all & ~bvalid_q;
   wire [ADDR_W-1:0] wr_addr = aw_hs ? awaddr : awaddr_q;
   wire [7:0] wr_byte = w_hs ? wdata[7:0] : wbyte_q;
   wire wr_strb0 = w_hs ? wstrb[0] : wstrb0_q;
   wire reg_id_t wr_sel = reg_of(wr_addr);
   wire wr_go = do_write & wr_strb0;
   wire aw_have_d = aw_all & ~do_write;
   wire w_have_d = w_all & ~do_write;
   wire bvalid_d = do_write | (bvalid_q & ~bready);
   wire [1:0] bresp_d = (wr_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'h0;
         w_have_q <= 1'h0;
         awready_q <= 1'h0;
         wready_q <= 1'h0;
         bvalid_q <= 1'h0;
         bresp_q <= `RESP_OKAY;
      end else if (ce) begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q <= ~w_have_d & ~bvalid_d;
         bvalid_q <= bvalid_d;
         if (do_write)
            bresp_q <= bresp_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= '0;
         wbyte_q <= 8'h00;
         wstrb0_q <= 1'h0;
      end else if (ce) begin
         if (aw_hs)
            awaddr_q <= awaddr;
         if (w_hs) begin
            wbyte_q <= wdata[7:0];
            wstrb0_q <= wstrb[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data2_q <= `RST_ZERO;
         dir2_q <= `RST_ZERO;
         fsel2_q <= `RST_P2_FSEL;
         trig_en_q <= 1'h0;
      end else if (ce && wr_go) begin
         if (wr_sel == REG_P2_DATA)
            data2_q <= wr_byte;
         if (wr_sel == REG_P2_DIR)
            dir2_q <= wr_byte;
         if (wr_sel == REG_P2_FSEL)
            fsel2_q <= (wr_byte & `P2_FSEL_WMASK) | `P2_FSEL_FIXED;
         if (wr_sel == REG_CONV_MODE)
            trig_en_q <= wr_byte[`BIT_TRIG_EN];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data3_q <= `RST_ZERO;
         dir3_q <= `RST_ZERO;
         fsel3_q <= `RST_ZERO;
         pull3_q <= `RST_ZERO;
      end else if (ce && wr_go) begin
         if (wr_sel == REG_P3_DATA)
            data3_q <= wr_byte;
         if (wr_sel == REG_P3_DIR)
            dir3_q <= wr_byte;
         if (wr_sel == REG_P3_FSEL)
            fsel3_q <= wr_byte;
         if (wr_sel == REG_P3_PULL)
            pull3_q <= wr_byte;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   wire ar_hs = ce & arvalid & arready_q;
   wire reg_id_t rd_sel = reg_of(araddr);
   wire [7:0] p2_view = port_view(dir2_q, data2_q, pin2_s);
   wire [7:0] p3_view = port_view(dir3_q, data3_q, pin3_s);
   wire [7:0] rd_byte =
      (rd_sel == REG_P2_DATA) ? p2_view :
      (rd_sel == REG_P3_DATA) ? p3_view :
      (rd_sel == REG_P2_DIR) ? `WO_READ :
      (rd_sel == REG_P3_DIR) ? `WO_READ :
      (rd_sel == REG_P2_FSEL) ? fsel2_q :
      (rd_sel == REG_P3_FSEL) ? fsel3_q :
      (rd_sel == REG_P3_PULL) ? pull3_q :
      (rd_sel == REG_CONV_MODE) ? {7'h00, trig_en_q} : 8'h00;
   wire rvalid_d = ar_hs | (rvalid_q & ~rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'h0;
         rvalid_q <= 1'h0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `RESP_OKAY;
      end else if (ce) begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_hs) begin
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= (rd_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // Port 2 pin control
   // ----------------------------------------------------------------
   // Pins taken by the counter or interrupt input never drive.
   wire [7:0] p2_in_force = {6'h00, fsel2_q[`BIT_COUNT_SEL], fsel2_q[`BIT_INT4_SEL]};
   wire [7:0] p2_dir_eff = dir2_q & ~p2_in_force;
   wire p2_live = (pmode == PM_ACTIVE) || (pmode == PM_SUBACTIVE);
   wire p2_float = (pmode == PM_RESET) || (pmode == PM_STANDBY);
   // Sleep, subsleep and watch keep the last drive, so the port 2 drive does not update then
   wire p2_hold = ~p2_live & ~p2_float;
   wire [7:0] p2_oe_n_d = p2_float ? 8'hff : ~p2_dir_eff;
   wire [7:0] p2_out_d = p2_float ? 8'h00 : data2_q;
   wire int4_on = fsel2_q[`BIT_INT4_SEL];
   wire cnt_on = fsel2_q[`BIT_COUNT_SEL];
   p2_alt_t p2_alt_d;
   assign p2_alt_d.count_dir = cnt_on ? pin2_s[`PIN_COUNT] : 1'h1;
   assign p2_alt_d.interrupt4 = int4_on ? pin2_s[`PIN_INT4] : 1'h1;
   assign p2_alt_d.trigger = (int4_on & trig_en_q) ? pin2_s[`PIN_INT4] : 1'h1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2_drv_q <= '{out: 8'h00, oe_n: 8'hff};
         p2_alt_q <= '{count_dir: 1'h1, interrupt4: 1'h1, trigger: 1'h1};
      end else if (ce) begin
         if (!p2_hold)
            p2_drv_q <= '{out: p2_out_d, oe_n: p2_oe_n_d};
         p2_alt_q <= p2_alt_d;
      end
   end

   // ----------------------------------------------------------------
   // Port 3 pin control
   // ----------------------------------------------------------------
   wire [7:0] gpio3 = ~fsel3_q;
   wire [7:0] p3_oe_n_d = (gpio3 & ~dir3_q) | (fsel3_q & ~p3_alt_en);
   wire [7:0] p3_out_d = (gpio3 & data3_q) | (fsel3_q & p3_alt_out);
   // Pull-ups are cut on any driving pin to avoid fighting the driver
   wire [7:0] p3_pull_d = pull3_q & p3_oe_n_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p3_drv_q <= '{out: 8'h00, oe_n: 8'hff};
         p3_pull_q <= 8'h00;
      end else if (ce) begin
         p3_drv_q <= '{out: p3_out_d, oe_n: p3_oe_n_d};
         p3_pull_q <= p3_pull_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign p2_drv = p2_drv_q;
   assign p2_alt = p2_alt_q;
   assign p3_drv = p3_drv_q;
   assign p3_pullup_on = p3_pull_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_p2_upper_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(ce) && $past(p2_live)
      |-> p2_drv_q.oe_n[7:2] == ~$past(dir2_q[7:2]))
      else $error("port 2 upper pins do not follow direction");

   a_p2_count_in: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(ce) && $past(p2_live) && $past(fsel2_q[1])
      |-> p2_drv_q.oe_n[1] && (p2_alt_q.count_dir == $past(pin2_s[1])))
      else $error("count pin not an input");

   a_p2_irq_trig: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(ce) && $past(fsel2_q[0])
      |-> (p2_alt_q.interrupt4 == $past(pin2_s[0]))
          && (p2_alt_q.trigger == ($past(trig_en_q) ? $past(pin2_s[0]) : 1'h1)))
      else $error("interrupt or trigger routing wrong");

   a_p2_float: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(ce) && $past(p2_float) |-> p2_drv_q.oe_n == 8'hff)
      else $error("port 2 drives in reset or standby");

   a_p2_retain: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && (!$past(ce) || $past(p2_hold)) |-> $stable(p2_drv_q))
      else $error("port 2 changed while held");

   a_p3_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(ce)
      |-> ((p3_drv_q.oe_n & ~$past(fsel3_q)) == (~$past(dir3_q) & ~$past(fsel3_q)))
          && ((p3_drv_q.out & ~$past(fsel3_q)) == ($past(data3_q) & ~$past(fsel3_q))))
      else $error("port 3 general pin drive wrong");

   a_port_read: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && (rd_sel == REG_P3_DATA)
      |=> rdata_q[7:0] == (($past(dir3_q) & $past(data3_q))
                         | (~$past(dir3_q) & $past(pin3_s))))
      else $error("port 3 read-back wrong");

   a_dir_reads_ones: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && (rd_sel == REG_P3_DIR || rd_sel == REG_P2_DIR)
      |=> rvalid_q && rdata_q == 32'h0000_00ff)
      else $error("direction read not all ones");

   a_reset_clear: assert property (@(posedge aclk)
      $past(!aresetn) |-> data3_q == 8'h00 && dir3_q == 8'h00 && p3_drv_q.oe_n == 8'hff)
      else $error("port 3 not cleared by reset");

   sequence s_p3_write;
      ce && do_write && wr_strb0 && (wr_sel == REG_P3_DATA);
   endsequence

   sequence s_p3_land(logic [7:0] v);
      (bvalid_q && data3_q == v) ##1 (!$past(ce) || fsel3_q[0] || p3_drv_q.out[0] == v[0]);
   endsequence

   a_write_reach: assert property (@(posedge aclk) disable iff (!aresetn)
      s_p3_write |=> s_p3_land($past(wr_byte)))
      else $error("port 3 write did not reach pin");

endmodule // gpio_p23

// ---- sim/pin_world.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Outside circuitry: resolves each pin from the device drive, the
// port 3 pull-ups and whatever the bench drives onto released pins
// ----------------------------------------------------------------
module pin_world
   import gpio_p23_pkg::*;
(
   input pin_drive_t p2_drv, // Port 2 drive from the device
   input pin_drive_t p3_drv, // Port 3 drive from the device
   input wire logic [7:0] p3_pullup_on, // Port 3 pull-ups
   input wire logic [7:0] ext2, // Outside level on port 2 pins
   input wire logic [7:0] ext3, // Outside level on port 3 pins
   output logic [7:0] p2_pin_in, // Resolved port 2 levels
   output logic [7:0] p3_pin_in // Resolved port 3 levels
);
   wire logic [7:0] p3_free;

   // A pull-up overrides the bench level but not the device drive, so it never hides the device
   assign p3_free = (ext3 & ~p3_pullup_on) | p3_pullup_on;
   assign p2_pin_in = (p2_drv.out & ~p2_drv.oe_n) | (ext2 & p2_drv.oe_n);
   assign p3_pin_in = (p3_drv.out & ~p3_drv.oe_n) | (p3_free & p3_drv.oe_n);
endmodule // pin_world

// ---- sim/port2_pinsel_port3_io_tb_top.sv ----
`timescale 1ns/100ps
`include "gpio_p23_cfg.svh"

module port2_pinsel_port3_io_tb_top;
   import gpio_p23_pkg::*;

   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   pmode_t pmode;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] p2_pin_in, p3_pin_in, p3_pullup_on, alt_out, alt_en, ext2, ext3;
   pin_drive_t p2_drv, p3_drv;
   p2_alt_t p2_alt;
   int miscompares, num_checks, i;
   pmode_t modes[6];
   logic [15:0] mode_exp[6];

   gpio_p23 dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pmode(pmode),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .p2_pin_in(p2_pin_in), .p2_drv(p2_drv), .p2_alt(p2_alt), .p3_pin_in(p3_pin_in),
      .p3_drv(p3_drv), .p3_pullup_on(p3_pullup_on), .p3_alt_out(alt_out),
      .p3_alt_en(alt_en));

   pin_world world (.p2_drv(p2_drv), .p3_drv(p3_drv), .p3_pullup_on(p3_pullup_on),
      .ext2(ext2), .ext3(ext3), .p2_pin_in(p2_pin_in), .p3_pin_in(p3_pin_in));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      miscompares++;
      $display("[ERR] %0t no answer to %s", $time, what);
      summarize();
   endtask

   // ----------------------------------------------------------------
   // Bus master: address and data offered together, bready held high
   // ----------------------------------------------------------------
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (ad && wd && bvalid) begin
            chk({30'h0, bresp}, {30'h0, er}, "write response");
            return;
         end
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      hang("write");
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic ad;
      ad = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (ad && rvalid) begin
            chk(rdata, ed, "read data");
            chk({30'h0, rresp}, {30'h0, er}, "read response");
            return;
         end
         if (!ad && arready) begin
            ad = 1'b1;
            arvalid <= 1'b0;
         end
      end
      hang("read");
   endtask

   // Drive path is one edge, input path two synchroniser edges
   task automatic settle();
      repeat (3) @(posedge aclk);
      #1;
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      miscompares = 0;
      num_checks = 0;
      ce = 1'b1;
      pmode = PM_ACTIVE;
      // Response channels stay ready for the whole run
      {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
      awaddr = 18'h00000;
      araddr = 18'h00000;
      wdata = 32'h00000000;
      wstrb = 4'h1;
      alt_out = 8'hff;
      alt_en = 8'h10;
      ext2 = 8'h96;
      ext3 = 8'h5a;
      modes = '{PM_SUBSLEEP, PM_WATCH, PM_STANDBY, PM_RESET, PM_SUBACTIVE, PM_ACTIVE};
      mode_exp = '{16'h3cf0, 16'h3cf0, 16'h00ff, 16'h00ff, 16'ha5f0, 16'ha5f0};
      do_reset();
      chk(p3_drv, 16'h00ff, "port 3 drive after reset");
      chk(p2_drv, 16'h00ff, "port 2 drive after reset");
      rd(`IDX_P2_FSEL, 32'h000000c0, `RESP_OKAY);
      rd(`IDX_P3_FSEL, 32'h00000000, `RESP_OKAY);
      rd(`IDX_P3_PULL, 32'h00000000, `RESP_OKAY);
      rd(`IDX_CONV_MODE, 32'h00000000, `RESP_OKAY);
      rd(`IDX_P3_DIR, 32'h000000ff, `RESP_OKAY);
      rd(`IDX_P2_DIR, 32'h000000ff, `RESP_OKAY);
      rd(`IDX_P2_DATA, 32'h00000096, `RESP_OKAY);
      rd(`IDX_P3_DATA, 32'h0000005a, `RESP_OKAY);
      rd(16'hffc0, 32'h00000000, `RESP_SLVERR);
      wr(16'hffc0, 8'h55, `RESP_SLVERR);

      // Port 2 plain outputs, then pins 1 and 0 handed to their functions
      wr(`IDX_P2_DATA, 8'h3c, `RESP_OKAY);
      wr(`IDX_P2_DIR, 8'hff, `RESP_OKAY);
      settle();
      chk(p2_drv, 16'h3c00, "port 2 all outputs");
      wr(`IDX_P2_FSEL, 8'h03, `RESP_OKAY);
      rd(`IDX_P2_FSEL, 32'h000000c3, `RESP_OKAY);
      settle();
      chk(p2_drv.oe_n, 8'h03, "pins 1 and 0 released");
      chk(p2_alt, 3'b101, "count and interrupt inputs");
      // Trigger enable routes pin 0 to the trigger input too; interrupt-4 stays selected
      wr(`IDX_CONV_MODE, 8'h01, `RESP_OKAY);
      settle();
      chk(p2_alt, 3'b100, "trigger input joins");
      wr(`IDX_P2_FSEL, 8'h00, `RESP_OKAY);
      wr(`IDX_P2_DIR, 8'h0f, `RESP_OKAY);
      settle();
      chk(p2_alt, 3'b111, "functions deselected idle");
      chk(p2_drv, 16'h3cf0, "mixed directions");
      rd(`IDX_P2_DATA, 32'h0000009c, `RESP_OKAY);

      // Port 2 pin states per operating mode
      pmode <= PM_SLEEP;
      wr(`IDX_P2_DATA, 8'ha5, `RESP_OKAY);
      settle();
      chk(p2_drv, 16'h3cf0, "sleep holds");
      for (i = 0; i < 6; i++) begin
         pmode = modes[i];
         settle();
         chk(p2_drv, mode_exp[i], "mode pin state");
      end
      ce = 1'b0;
      pmode = PM_STANDBY;
      settle();
      chk(p2_drv, 16'ha5f0, "frozen while ce low");
      ce = 1'b1;
      pmode = PM_ACTIVE;

      // Port 3 data, direction, function select and pull-ups
      wr(`IDX_P3_DATA, 8'ha5, `RESP_OKAY);
      wr(`IDX_P3_DIR, 8'hf0, `RESP_OKAY);
      rd(`IDX_P3_DIR, 32'h000000ff, `RESP_OKAY);
      settle();
      chk(p3_drv, 16'ha50f, "port 3 drive");
      rd(`IDX_P3_DATA, 32'h000000aa, `RESP_OKAY);
      wr(`IDX_P3_FSEL, 8'h30, `RESP_OKAY);
      settle();
      chk(p3_drv, 16'hb52f, "peripheral owns pins 5 and 4");
      wr(`IDX_P3_PULL, 8'hff, `RESP_OKAY);
      rd(`IDX_P3_PULL, 32'h000000ff, `RESP_OKAY);
      wstrb <= 4'h0;
      wr(`IDX_P3_PULL, 8'h00, `RESP_OKAY);
      wstrb <= 4'h1;
      settle();
      chk(p3_pullup_on, 8'h2f, "pull-ups off on driven pins");
      rd(`IDX_P3_DATA, 32'h000000af, `RESP_OKAY);

      // Second reset in mid-run
      do_reset();
      chk(p3_drv, 16'h00ff, "port 3 inputs again");
      rd(`IDX_P3_DATA, 32'h0000005a, `RESP_OKAY);
      rd(`IDX_P3_PULL, 32'h00000000, `RESP_OKAY);
      rd(`IDX_P2_FSEL, 32'h000000c0, `RESP_OKAY);
      wr(`IDX_P3_DIR, 8'hff, `RESP_OKAY);
      settle();
      chk(p3_drv, 16'h0000, "cleared data drives low");
      summarize();
   end
endmodule // port2_pinsel_port3_io_tb_top
